// File: dsp_alu_pkg.sv
package dsp_alu_pkg;
    // field positions of the 32-bit instruction word
    localparam int CLASS_LSB = 28;
    localparam int OP_LSB = 23;
    localparam int ADEST_LSB = 21;
    localparam int WSRC_LSB = 18;
    localparam int WDST_LSB = 15;
    localparam int LSRC_LSB = 11;
    localparam int LDST_BIT = 10;
    localparam int RSRC_LSB = 6;
    localparam int RDST_BIT = 5;
    localparam int SHAMT_LSB = 0;
    // instruction class codes, bits 31:28
    localparam logic [3:0] CLS_IMM = 4'h0;
    localparam logic [3:0] CLS_IND = 4'h1;
    localparam logic [3:0] CLS_DIR = 4'h2;
    localparam logic [3:0] CLS_SHIFT = 4'h3;
    localparam logic [3:0] CLS_MOVE = 4'h4;
    localparam logic [3:0] CLS_BR_IMM = 4'h5;
    localparam logic [3:0] CLS_BR_COMP = 4'h6;
    localparam logic [3:0] CLS_PTR_SETUP = 4'h7;
    localparam logic [3:0] CLS_REG_SETUP = 4'h8;
    localparam int NUM_CLASSES = 9;
    // arithmetic modes
    localparam logic [1:0] MODE_REAL = 2'h0;
    localparam logic [1:0] MODE_COMPLEX = 2'h1;
    localparam logic [1:0] MODE_DOUBLE = 2'h2;
    // timing: one machine cycle in clock cycles, rounded up
    localparam int MACHINE_NS = 100;
    localparam int CLOCK_NS = 4;
    localparam int MC_CYCLES = (MACHINE_NS + CLOCK_NS - 1) / CLOCK_NS;
    // writeback bus sources
    localparam logic [2:0] WB_ALU = 3'h0;
    localparam logic [2:0] WB_FIFO = 3'h5;
    // condition code bit positions and reset value
    localparam int CC_C = 0;
    localparam int CC_V = 1;
    localparam int CC_Z = 2;
    localparam int CC_N = 3;
    localparam logic [3:0] CCR_RESET = 4'h0;
    localparam logic [31:0] RESULT_RESET = 32'h0;
    // alu operation codes
    localparam logic [4:0] OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADD_WITH_CARRY_OP = 5'h02, OP_ADD_SHIFTED_OP = 5'h03;
    localparam logic [4:0] OP_CONJUGATE_ADD_OP = 5'h04, OP_SBC = 5'h05, OP_REVERSE_SUBTRACT_CARRY_OP = 5'h06, OP_SUB = 5'h07;
    localparam logic [4:0] OP_REVERSE_DIFFERENCE_OP = 5'h08, OP_SHIFTED_DIFFERENCE_OP = 5'h09, OP_AND = 5'h0A, OP_OR = 5'h0B;
    localparam logic [4:0] OP_XOR = 5'h0C, OP_COM_L = 5'h0D, OP_COM_R = 5'h0E, OP_ASL = 5'h0F;
    localparam logic [4:0] OP_ASR = 5'h10, OP_LSL = 5'h11, OP_LOGIC_LEFT_BYTE_SHIFT_OP = 5'h12, OP_LSR = 5'h13;
    localparam logic [4:0] OP_LOGIC_RIGHT_BYTE_SHIFT_OP = 5'h14, OP_ROR = 5'h15, OP_LOAD_FLAGS_FROM_LEFT_OP = 5'h16, OP_TRA_L = 5'h17;
    localparam logic [4:0] OP_TRA_R = 5'h18, OP_EDGE = 5'h19, OP_ABS = 5'h1A, OP_CLR = 5'h1B;
    localparam logic [4:0] OP_SET = 5'h1C;
endpackage

// File: dsp_instruction_alu.sv
module dsp_instruction_alu #(
    parameter int DATA_W = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic instr_valid, // program word offered
    input wire logic [31:0] instr_word,
    output logic instr_ready, // word taken when valid and ready
    input wire logic [1:0] arith_mode,
    input wire logic [DATA_W-1:0] left_bus, // left operand bus value
    input wire logic [DATA_W-1:0] right_bus, // right operand bus value
    output logic [dsp_alu_pkg::NUM_CLASSES-1:0] class_sel,
    output logic wb_enable,
    output logic [2:0] wb_source,
    output logic [2:0] wb_dest_ptr,
    output logic [3:0] left_src_addr,
    output logic left_direct,
    output logic left_dest,
    output logic [3:0] right_src_ptr,
    output logic right_is_imm,
    output logic right_dest,
    output logic [4:0] alu_op,
    output logic [1:0] alu_dest,
    output logic [DATA_W-1:0] alu_result,
    output logic [3:0] cond_flags,
    output logic illegal_op,
    output logic exec_done
);
    import dsp_alu_pkg::*;

    // wait figures for the checks below
    localparam int REAL_WAIT = MC_CYCLES - 1;
    localparam int LONG_WAIT = 2 * MC_CYCLES - 1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_t;

    // sequencing state
    state_t state_q, state_d;
    logic [6:0] cnt_q, cnt_d; // clocks left in the instruction
    // decoded fields, held for the whole instruction
    logic [NUM_CLASSES-1:0] class_q, class_d;
    logic wb_en_q, wb_en_d;
    logic [2:0] wb_src_q, wb_src_d, wb_dst_q, wb_dst_d;
    logic [3:0] lsrc_q, lsrc_d, rsrc_q, rsrc_d;
    logic ldir_q, ldir_d, ldst_q, ldst_d, rimm_q, rimm_d, rdst_q, rdst_d;
    logic [4:0] op_q, op_d;
    logic [1:0] adest_q, adest_d;
    logic illegal_q, illegal_d;
    // alu state
    logic [DATA_W-1:0] result_q, result_d;
    logic [3:0] ccr_q, ccr_d; // condition code register
    // helpers
    logic accept;
    logic [3:0] cls;
    logic [4:0] raw_op, op_eff;
    logic calc_class;
    logic [DATA_W-1:0] op_l, op_r;
    logic [4:0] shamt;

    // leading sign bits minus one: places the binary point
    function automatic logic [5:0] sign_run(input logic [DATA_W-1:0] v);
        logic [5:0] n;
        logic stop;
        n = 6'h00;
        stop = 1'b0;
        for (int i = DATA_W - 2; i >= 0; i--) begin
            if (!stop && v[i] == v[DATA_W-1]) begin
                n = n + 6'h01;
            end else begin
                stop = 1'b1;
            end
        end
        return n;
    endfunction

    // sum with carry out on top
    function automatic logic [DATA_W:0] add_c(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                              input logic cin);
        return {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
    endfunction

    // signed overflow of a + b giving s
    function automatic logic ovf(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                 input logic [DATA_W-1:0] s);
        return (a[DATA_W-1] == b[DATA_W-1]) && (s[DATA_W-1] != a[DATA_W-1]);
    endfunction

    assign accept = instr_valid && instr_ready;
    assign cls = instr_word[CLASS_LSB+:4];
    assign raw_op = instr_word[OP_LSB+:5];
    assign shamt = instr_word[SHAMT_LSB+:5];
    assign calc_class = (cls == CLS_IMM) || (cls == CLS_IND) || (cls == CLS_DIR);

    // op gating: shift class keeps only shift codes
    always_comb begin
        op_eff = OP_NOP;
        illegal_d = 1'b0;
        if (calc_class) begin
            // codes past the table act as nop, never as a default-branch result
            op_eff = (raw_op > OP_SET) ? OP_NOP : raw_op;
            illegal_d = (raw_op > OP_SET);
        end else if (cls == CLS_SHIFT) begin
            if (raw_op >= OP_ASL && raw_op <= OP_ROR) begin
                op_eff = raw_op;
            end else begin
                illegal_d = 1'b1;
            end
        end else begin
            illegal_d = (raw_op != OP_NOP); // code ignored outside calc
        end
    end

    // operands consumed in the taking cycle, not latched
    always_comb begin
        op_l = left_bus;
        // right operand from the word itself in immediate class, else from the right bus
        if (cls == CLS_IMM) begin
            op_r = DATA_W'($signed({instr_word[WDST_LSB+:6], instr_word[RSRC_LSB+:4]}));
        end else begin
            op_r = right_bus;
        end
    end

    always_comb begin
        class_d = class_q;
        wb_en_d = wb_en_q;
        wb_src_d = wb_src_q;
        wb_dst_d = wb_dst_q;
        lsrc_d = lsrc_q;
        ldir_d = ldir_q;
        ldst_d = ldst_q;
        rsrc_d = rsrc_q;
        rimm_d = rimm_q;
        rdst_d = rdst_q;
        op_d = op_q;
        adest_d = adest_q;
        if (accept) begin
            class_d = '0;
            if (cls <= CLS_REG_SETUP) begin
                class_d[cls] = 1'b1;
            end
            op_d = op_eff;
            adest_d = instr_word[ADEST_LSB+:2];
            wb_src_d = (instr_word[WSRC_LSB+:3] > WB_FIFO) ? WB_ALU : instr_word[WSRC_LSB+:3];
            wb_dst_d = instr_word[WDST_LSB+:3];
            lsrc_d = instr_word[LSRC_LSB+:4];
            ldst_d = instr_word[LDST_BIT];
            rsrc_d = instr_word[RSRC_LSB+:4];
            rdst_d = instr_word[RDST_BIT];
            wb_en_d = (cls == CLS_IND) || (cls == CLS_DIR) || (cls == CLS_MOVE);
            ldir_d = (cls == CLS_DIR) || (cls == CLS_SHIFT) || (cls == CLS_MOVE);
            rimm_d = (cls == CLS_IMM);
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        exec_done = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    state_d = ST_EXEC;
                    // branches count as control: two machine cycles
                    if (arith_mode == MODE_REAL && cls != CLS_BR_IMM && cls != CLS_BR_COMP) begin
                        cnt_d = 7'(MC_CYCLES - 2);
                    end else begin
                        cnt_d = 7'(2 * MC_CYCLES - 2);
                    end
                end
            end
            ST_EXEC: begin
                if (cnt_q == 7'h00) begin
                    exec_done = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 7'h01;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = 7'h00;
            end
        endcase
    end

    // one word per instruction, taken only when idle
    assign instr_ready = (state_q == ST_IDLE);

    // alu evaluation on the taking cycle
    always_comb begin
        logic [DATA_W:0] s;
        logic [DATA_W-1:0] lsh;
        logic arith;
        s = '0;
        lsh = op_l << shamt;
        arith = 1'b0;
        result_d = result_q;
        ccr_d = ccr_q;
        if (accept) begin
            case (op_eff)
                OP_ADD: begin s = add_c(op_l, op_r, 1'b0); arith = 1'b1; end
                // carry flag from the previous arithmetic op or flag load
                OP_ADD_WITH_CARRY_OP: begin s = add_c(op_l, op_r, ccr_q[CC_C]); arith = 1'b1; end
                OP_ADD_SHIFTED_OP: begin s = add_c(lsh, op_r, 1'b0); arith = 1'b1; end
                // real parts add, imaginary left negated
                OP_CONJUGATE_ADD_OP: s = {1'b0, op_r[31:16] + op_l[31:16], op_r[15:0] - op_l[15:0]};
                OP_SBC: begin s = add_c(op_l, ~op_r, ccr_q[CC_C]); arith = 1'b1; end
                OP_REVERSE_SUBTRACT_CARRY_OP: begin s = add_c(op_r, ~op_l, ccr_q[CC_C]); arith = 1'b1; end
                OP_SUB: begin s = add_c(op_l, ~op_r, 1'b1); arith = 1'b1; end
                OP_REVERSE_DIFFERENCE_OP: begin s = add_c(op_r, ~op_l, 1'b1); arith = 1'b1; end
                OP_SHIFTED_DIFFERENCE_OP: begin s = add_c(lsh, ~op_r, 1'b1); arith = 1'b1; end
                OP_AND: s = {1'b0, op_l & op_r};
                OP_OR: s = {1'b0, op_l | op_r};
                OP_XOR: s = {1'b0, op_l ^ op_r};
                OP_COM_L: s = {1'b0, ~op_l};
                OP_COM_R: s = {1'b0, ~op_r};
                // single steps in calc, field count in shift class; byte shifts always move 8
                OP_ASL: s = {1'b0, op_l << ((cls == CLS_SHIFT) ? shamt : 5'h01)};
                OP_ASR: s = {1'b0, $signed(op_l) >>> ((cls == CLS_SHIFT) ? shamt : 5'h01)};
                OP_LSL: s = {1'b0, op_l << ((cls == CLS_SHIFT) ? shamt : 5'h01)};
                OP_LSR: s = {1'b0, op_l >> ((cls == CLS_SHIFT) ? shamt : 5'h01)};
                OP_LOGIC_LEFT_BYTE_SHIFT_OP: s = {1'b0, op_l << 8};
                OP_LOGIC_RIGHT_BYTE_SHIFT_OP: s = {1'b0, op_l >> 8};
                OP_ROR: s = {1'b0, DATA_W'({op_l, op_l} >> ((cls == CLS_SHIFT) ? shamt : 5'h01))};
                OP_TRA_L: s = {1'b0, op_l};
                OP_TRA_R: s = {1'b0, op_r};
                OP_EDGE: s = {{(DATA_W - 5){1'b0}}, sign_run(op_l)};
                OP_ABS: s = {1'b0, op_l[DATA_W-1] ? (~op_l + 1'b1) : op_l};
                OP_CLR: s = '0;
                OP_SET: s = {1'b0, {DATA_W{1'b1}}};
                default: s = {1'b0, result_q}; // nop and load-flags keep the result
            endcase
            if (op_eff == OP_LOAD_FLAGS_FROM_LEFT_OP) begin
                // left bus straight into the flags
                ccr_d = op_l[3:0];
            end else if (op_eff != OP_NOP) begin
                result_d = s[DATA_W-1:0];
                ccr_d[CC_Z] = (s[DATA_W-1:0] == '0);
                ccr_d[CC_N] = s[DATA_W-1];
                if (arith) begin
                    // carry kept for the next carry op
                    ccr_d[CC_C] = s[DATA_W];
                    ccr_d[CC_V] = ovf(op_l, op_r, s[DATA_W-1:0]);
                end
            end
        end
    end

    // all state registers, synchronous reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 7'h00;
            class_q <= '0;
            wb_en_q <= 1'b0;
            wb_src_q <= WB_ALU;
            wb_dst_q <= 3'h0;
            lsrc_q <= 4'h0;
            ldir_q <= 1'b0;
            ldst_q <= 1'b0;
            rsrc_q <= 4'h0;
            rimm_q <= 1'b0;
            rdst_q <= 1'b0;
            op_q <= OP_NOP;
            adest_q <= 2'h0;
            illegal_q <= 1'b0;
            result_q <= RESULT_RESET;
            ccr_q <= CCR_RESET;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            class_q <= class_d;
            wb_en_q <= wb_en_d;
            wb_src_q <= wb_src_d;
            wb_dst_q <= wb_dst_d;
            lsrc_q <= lsrc_d;
            ldir_q <= ldir_d;
            ldst_q <= ldst_d;
            rsrc_q <= rsrc_d;
            rimm_q <= rimm_d;
            rdst_q <= rdst_d;
            op_q <= op_d;
            adest_q <= adest_d;
            illegal_q <= accept ? illegal_d : illegal_q;
            result_q <= result_d;
            ccr_q <= ccr_d;
        end
    end

    // outputs straight from registers
    assign class_sel = class_q;
    assign wb_enable = wb_en_q;
    assign wb_source = wb_src_q;
    assign wb_dest_ptr = wb_dst_q;
    assign left_src_addr = lsrc_q;
    assign left_direct = ldir_q;
    assign left_dest = ldst_q;
    assign right_src_ptr = rsrc_q;
    assign right_is_imm = rimm_q;
    assign right_dest = rdst_q;
    assign alu_op = op_q;
    assign alu_dest = adest_q;
    assign alu_result = result_q;
    assign cond_flags = ccr_q;
    assign illegal_op = illegal_q;

    // checks
    a_class_onehot: assert property (@(posedge clock) disable iff (!rst_n) $onehot0(class_sel))
        else $error("class select not one-hot");
    a_real_timing: assert property (@(posedge clock) disable iff (!rst_n)
        accept && arith_mode == MODE_REAL && cls != CLS_BR_IMM && cls != CLS_BR_COMP
        |-> ##REAL_WAIT exec_done)
        else $error("real mode instruction not one machine cycle");
    a_long_timing: assert property (@(posedge clock) disable iff (!rst_n)
        accept && arith_mode != MODE_REAL |-> ##LONG_WAIT exec_done)
        else $error("long mode instruction not two machine cycles");
    a_single_word: assert property (@(posedge clock) disable iff (!rst_n)
        accept |=> !instr_ready [*3])
        else $error("second word taken during execution");
    a_imm_no_wb: assert property (@(posedge clock) disable iff (!rst_n)
        accept && cls == CLS_IMM |=> right_is_imm && !wb_enable)
        else $error("immediate class decode wrong");
    a_alu_gated: assert property (@(posedge clock) disable iff (!rst_n)
        accept && !calc_class && cls != CLS_SHIFT |=> alu_op == OP_NOP && $stable(alu_result))
        else $error("alu code used outside calculation class");
    a_add_sum: assert property (@(posedge clock) disable iff (!rst_n)
        accept && op_eff == OP_ADD |=> alu_result == $past(op_l) + $past(op_r))
        else $error("add result wrong");
    a_rev_sub: assert property (@(posedge clock) disable iff (!rst_n)
        accept && op_eff == OP_REVERSE_DIFFERENCE_OP |=> alu_result == $past(op_r) - $past(op_l))
        else $error("reverse subtract wrong");
    a_load_flags: assert property (@(posedge clock) disable iff (!rst_n)
        accept && op_eff == OP_LOAD_FLAGS_FROM_LEFT_OP |=> cond_flags == $past(left_bus[3:0]))
        else $error("flags not loaded from left bus");
    c_real: cover property (@(posedge clock) accept && arith_mode == MODE_REAL ##REAL_WAIT exec_done);
    c_complex: cover property (@(posedge clock) accept && arith_mode == MODE_COMPLEX);
    c_add_with_carry_op: cover property (@(posedge clock) accept && op_eff == OP_ADD_WITH_CARRY_OP && ccr_q[CC_C]);
    c_shift: cover property (@(posedge clock) accept && cls == CLS_SHIFT && op_eff == OP_ROR);
endmodule

// File: dsp_program_source.sv
// program word and operand driver feeding the block
module dsp_program_source (
    input wire logic clock,
    input wire logic instr_ready,
    output logic instr_valid,
    output logic [31:0] instr_word,
    output logic [1:0] arith_mode,
    output logic [31:0] left_bus,
    output logic [31:0] right_bus
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle lines at time zero
    initial begin
        instr_valid = 1'b0;
        instr_word = 32'h0;
        arith_mode = 2'h0;
        left_bus = 32'h0;
        right_bus = 32'h0;
    end
    // offer one word, hold it and the operands until the take edge
    // one whole word
    task automatic offer(input logic [31:0] w, input logic [1:0] m, input logic [31:0] l,
                         input logic [31:0] r, input int slow);
        repeat (slow + 1) @(posedge clock);
        #1;
        instr_valid = 1'b1;
        instr_word = w;
        arith_mode = m;
        left_bus = l;
        right_bus = r;
        do @(posedge clock); while (instr_ready !== 1'b1);
        #1;
        instr_valid = 1'b0;
        instr_word = ~w;
        left_bus = ~l;
        right_bus = ~r;
    endtask
endmodule

// File: test_dsp_instruction_alu.sv
module test_dsp_instruction_alu;
    timeunit 1ns;
    timeprecision 100ps;
    import dsp_alu_pkg::*;
    // one expected outcome per instruction
    typedef struct {
        logic [31:0] res;
        logic rk;
        logic [2:0] fl;
        logic [8:0] cs;
        logic [4:0] op;
        logic [2:0] wbs;
        logic [3:0] bits;
        logic [14:0] fld;
        int lat;
    } note_t;
    logic clock, rst_n, instr_valid, instr_ready, wb_enable, left_direct, left_dest;
    logic right_is_imm, right_dest, illegal_op, exec_done;
    logic [31:0] instr_word, left_bus, right_bus, alu_result;
    logic [1:0] arith_mode, alu_dest;
    logic [8:0] class_sel;
    logic [2:0] wb_source, wb_dest_ptr;
    logic [3:0] left_src_addr, right_src_ptr, cond_flags;
    logic [4:0] alu_op;
    logic [31:0] last_res; // model of the result register
    logic res_known; // result model valid; set at start and after each executed op except flag load, never cleared
    logic [2:0] fl_m; // model flags n, z, c
    int seed = 73;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0 = 0;
    note_t q[$];
    dsp_instruction_alu dut_u (.clock, .rst_n, .instr_valid, .instr_word, .instr_ready, .arith_mode,
        .left_bus, .right_bus, .class_sel, .wb_enable, .wb_source, .wb_dest_ptr, .left_src_addr,
        .left_direct, .left_dest, .right_src_ptr, .right_is_imm, .right_dest, .alu_op, .alu_dest,
        .alu_result, .cond_flags, .illegal_op, .exec_done);
    dsp_program_source src_u (.clock, .instr_ready, .instr_valid, .instr_word, .arith_mode,
        .left_bus, .right_bus);
    // 4 ns clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // compare and count
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // reference alu: carry out and result; s is the plain shift step
    function automatic logic [32:0] alu_ref(input logic [4:0] op, input logic [31:0] l,
        input logic [31:0] r, input logic [4:0] n, input logic [4:0] s, input logic c);
        logic [31:0] ls;
        int k;
        ls = l << n;
        k = 0;
        alu_ref = {c, 32'h0};
        case (op)
            OP_ADD: alu_ref = {1'b0, l} + {1'b0, r};
            OP_ADD_WITH_CARRY_OP: alu_ref = {1'b0, l} + {1'b0, r} + 33'(c);
            OP_ADD_SHIFTED_OP: alu_ref = {1'b0, ls} + {1'b0, r};
            OP_CONJUGATE_ADD_OP: alu_ref = {c, r[31:16] + l[31:16], r[15:0] - l[15:0]};
            OP_SBC: alu_ref = {1'b0, l} + {1'b0, ~r} + 33'(c);
            OP_REVERSE_SUBTRACT_CARRY_OP: alu_ref = {1'b0, r} + {1'b0, ~l} + 33'(c);
            OP_SUB: alu_ref = {1'b0, l} + {1'b0, ~r} + 33'h1;
            OP_REVERSE_DIFFERENCE_OP: alu_ref = {1'b0, r} + {1'b0, ~l} + 33'h1;
            OP_SHIFTED_DIFFERENCE_OP: alu_ref = {1'b0, ls} + {1'b0, ~r} + 33'h1;
            OP_AND: alu_ref = {c, l & r};
            OP_OR: alu_ref = {c, l | r};
            OP_XOR: alu_ref = {c, l ^ r};
            OP_COM_L: alu_ref = {c, ~l};
            OP_COM_R: alu_ref = {c, ~r};
            OP_ASL, OP_LSL: alu_ref = {c, l << s};
            OP_ASR: alu_ref = {c, 32'($signed(l) >>> s)};
            OP_LOGIC_LEFT_BYTE_SHIFT_OP: alu_ref = {c, l << 8};
            OP_LSR: alu_ref = {c, l >> s};
            OP_LOGIC_RIGHT_BYTE_SHIFT_OP: alu_ref = {c, l >> 8};
            OP_ROR: alu_ref = {c, (l >> s) | (l << (6'd32 - s))};
            OP_TRA_L: alu_ref = {c, l};
            OP_TRA_R: alu_ref = {c, r};
            OP_EDGE: begin
                while (k < 31 && l[30-k] == l[31]) k++;
                alu_ref = {c, 32'(k)};
            end
            OP_ABS: alu_ref = {c, l[31] ? -l : l};
            OP_SET: alu_ref = {c, 32'hFFFFFFFF};
            default: alu_ref = {c, 32'h0};
        endcase
    endfunction
    // note the outcome, then hand the word to the program source
    task automatic run(input logic [3:0] cls, input logic [4:0] op, input logic [31:0] l,
                       input logic [31:0] r);
        note_t nt;
        logic [31:0] w, rv;
        logic [32:0] y;
        logic [1:0] m;
        logic go;
        w = {cls, op, 23'($random(seed))};
        m = 2'($unsigned($random(seed)) % 3);
        // sign-extended immediate on the right side
        rv = (cls == CLS_IMM) ? {{22{w[20]}}, w[20:15], w[9:6]} : r;
        go = (cls inside {CLS_IMM, CLS_IND, CLS_DIR}) ? (op != OP_NOP && op <= OP_SET)
            : (cls == CLS_SHIFT && op inside {[OP_ASL:OP_ROR]});
        y = alu_ref(op, l, rv, w[4:0], (cls == CLS_SHIFT) ? w[4:0] : 5'h1, fl_m[0]);
        nt.op = go ? op : OP_NOP;
        nt.bits = {cls inside {CLS_IND, CLS_DIR, CLS_MOVE}, cls inside {CLS_DIR, CLS_SHIFT, CLS_MOVE},
            cls == CLS_IMM, !go && (op != OP_NOP || cls == CLS_SHIFT)};
        nt.fld = {w[22:21], w[17:15], w[14:11], w[10], w[9:6], w[5]};
        nt.wbs = (w[20:18] > WB_FIFO) ? WB_ALU : w[20:18];
        nt.cs = 9'h1 << cls;
        nt.lat = (m == MODE_REAL && !(cls inside {CLS_BR_IMM, CLS_BR_COMP})) ? 24 : 49;
        // flags straight from the left bus
        if (go && op == OP_LOAD_FLAGS_FROM_LEFT_OP) begin
            fl_m = {l[3], l[2], l[0]};
        end else if (go) begin
            last_res = y[31:0];
            res_known = 1'b1;
            fl_m[2:1] = {y[31], y[31:0] == 32'h0};
            // carry kept from the last add or subtract
            if (op inside {[OP_ADD:OP_ADD_SHIFTED_OP], [OP_SBC:OP_SHIFTED_DIFFERENCE_OP]}) fl_m[0] = y[32];
        end
        nt.res = last_res;
        nt.rk = res_known;
        nt.fl = fl_m;
        q.push_back(nt);
        src_u.offer(w, m, l, r, $unsigned($random(seed)) % 3);
    endtask
    // watcher: pair each completion with the oldest note
    always @(posedge clock) begin
        note_t nt;
        cyc++;
        if (rst_n === 1'b1 && instr_valid === 1'b1 && instr_ready === 1'b1) t0 = cyc;
        if (rst_n === 1'b1 && exec_done === 1'b1) begin
            if (q.size() == 0) begin
                chk("spurious done", 64'h1, 64'h0);
            end else begin
                nt = q.pop_front();
                chk("latency", 64'(cyc - t0), 64'(nt.lat));
                chk("class", 64'(class_sel), 64'(nt.cs));
                chk("op", 64'(alu_op), 64'(nt.op));
                chk("decode", 64'({wb_enable, left_direct, right_is_imm, illegal_op}), 64'(nt.bits));
                chk("flags", 64'({cond_flags[CC_N], cond_flags[CC_Z], cond_flags[CC_C]}), 64'(nt.fl));
                if (nt.bits[3]) chk("wb source", 64'(wb_source), 64'(nt.wbs));
                chk("fields", 64'({alu_dest, wb_dest_ptr, left_src_addr, left_dest, right_src_ptr, right_dest}), 64'(nt.fld));
                if (nt.rk) chk("result", 64'(alu_result), 64'(nt.res));
            end
        end
    end
    // hang guard, well beyond the expected run
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
    // main sequence
    initial begin
        logic [31:0] a, b;
        logic [4:0] op;
        logic [3:0] cls;
        last_res = RESULT_RESET;
        res_known = 1'b1;
        fl_m = 3'h0;
        rst_n = 1'b0;
        repeat (12) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chk("ready at reset", 64'(instr_ready), 64'h1);
        chk("result at reset", 64'(alu_result), 64'(RESULT_RESET));
        // codes 01 to 1E, rotating through the calc classes; 1D and 1E refused
        for (int i = 1; i <= 30; i++) begin
            op = 5'(i);
            a = $random(seed);
            b = $random(seed);
            cls = (i % 3 == 0) ? CLS_IMM : ((i % 3 == 1) ? CLS_IND : CLS_DIR);
            // shift, edge and abs ops get equal sides so the side does not matter
            if (op inside {[OP_ASL:OP_ROR], OP_EDGE, OP_ABS}) begin
                b = a;
                if (cls == CLS_IMM) cls = CLS_IND;
            end
            run(cls, op, a, b);
        end
        // carry chains: set carry by add or by flag load, then consume it
        for (int j = 0; j < 6; j++) begin
            run(CLS_IND, (j < 3) ? OP_ADD : OP_LOAD_FLAGS_FROM_LEFT_OP, $random(seed), $random(seed));
            run(CLS_DIR, (j % 3 == 0) ? OP_ADD_WITH_CARRY_OP : ((j % 3 == 1) ? OP_SBC : OP_REVERSE_SUBTRACT_CARRY_OP), $random(seed), $random(seed));
        end
        // shift class by programmed count, then refused codes
        for (int i = OP_ASL; i <= OP_ROR + 2; i++) begin
            a = $random(seed);
            run(CLS_SHIFT, (i <= OP_ROR) ? 5'(i) : ((i == OP_ROR + 1) ? OP_ADD : OP_NOP), a, a);
        end
        // move, branch and setup classes keep result and flags, refuse alu codes
        for (int c = CLS_MOVE; c <= CLS_REG_SETUP; c++) begin
            run(4'(c), OP_ADD, $random(seed), $random(seed));
        end
        for (int k = 0; k < 200 && q.size() != 0; k++) @(posedge clock);
        chk("pending notes", 64'(q.size()), 64'h0);
        final_report();
    end
endmodule
